// ---- hdl/twcp_cfg_port.sv ----
// Two-wire write-only configuration port with its bandwidth and amplitude registers
//
// Summary of operation
// - Both lines rest high when idle; a start is detected at any time, with no idle arming.
// - Start is data falling while serial clock stays high.
// - Frame: start, 3 address bits, 8 data bits, MSB first, then stop.
// - Bits sampled while clock high into an 11-bit shift register.
// - Stop is data rising after the clock went high.
// - At a stop ending a whole frame the 8 data bits go to the addressed register.
// - Address decoded into eight select lines; lines 4 and 5 each enable a copy.
// - Only addresses 100b and 101b hold registers.
// - Register 100b: bandwidth code in bits 7..4, bits 3..0 unused.
// - Register 101b: swing code bits 7..6, trim code bits 5..0.
// - Bandwidth code picks sixteen falling settings, 4.39 down to 0.73 GHz.
// - Swing code gives 400, 600, 800 or 1000 mVpp.
// - Trim code 0 gives 86.75 kOhm, minus 1.25 kOhm per step.
// - Each trim bit shunts one binary-weighted resistor; fixed part remains.
// - Signal present when amplitude suffices; input absent below threshold.
// - Swing code resets to 10, 800 mVpp.
`timescale 1ns/1ps
`default_nettype none
module twcp_cfg_port
   import twcp_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        serial_clk,
   input  wire logic        serial_data,
   input  wire logic        amp_above_thr,
   output logic [3:0]       band_code,
   output logic [1:0]       swing_code,
   output logic [5:0]       trim_code,
   output logic [5:0]       trim_shunt_en,
   output logic [12:0]      band_mhz,
   output logic [9:0]       swing_mvpp,
   output logic [16:0]      trim_ohm,
   output logic             cfg_written,
   output logic             signal_present_flag,
   output logic             input_absent_flag_o,
   output logic             input_absent_flag_oe_n
);

   typedef struct packed {
      logic        scl_s1;
      logic        scl_s2;
      logic        scl_s3;
      logic        sda_s1;
      logic        sda_s2;
      logic        sda_s3;
      logic        done_s1;
      logic        done_s2;
      logic [3:0]  falls;
      logic        amp_s1;
      logic        amp_s2;
      logic [7:0]  bandwidth_select;
      logic [7:0]  amplitude_and_threshold;
      logic [12:0] band_mhz;
      logic [9:0]  swing_mvpp;
      logic [16:0] trim_ohm;
      logic        written;
      logic        present;
   } twcp_core_st_t;

   twcp_core_st_t            st_ff;
   twcp_core_st_t            nxt_st;
   twcp_link_if              lk ();
   logic [TWCP_NUM_SEL-1:0]  reg_sel;
   logic [TWCP_ADDR_W-1:0]   frame_addr;
   logic [TWCP_DATA_W-1:0]   frame_data;
   logic                     stop_seen;
   logic                     start_seen;
   logic                     scl_fall;
   logic [3:0]               band_next;
   logic [1:0]               swing_next;
   logic [5:0]               trim_next;

   twcp_framer u_framer (
      .serial_clk  (serial_clk),
      .rst_n       (rst_n),
      .serial_data (serial_data),
      .lk          (lk.link)
   );

   assign frame_addr = lk.frame_word[TWCP_FRAME_W-1:TWCP_FRM_ADDR_LSB];
   assign frame_data = lk.frame_word[TWCP_DATA_W-1:0];

   // One select line per address; unused ones go nowhere
   genvar gi;
   generate
      for (gi = 0; gi < TWCP_NUM_SEL; gi++) begin : g_sel
         assign reg_sel[gi] = (frame_addr == TWCP_ADDR_W'(gi));
      end
   endgenerate

   // Both pins pass three flops; the edge test looks at the second and third only
   assign stop_seen = st_ff.scl_s2 & st_ff.scl_s3 & st_ff.sda_s2 & ~st_ff.sda_s3;
   assign start_seen = st_ff.scl_s2 & st_ff.scl_s3 & ~st_ff.sda_s2 & st_ff.sda_s3;
   assign scl_fall   = st_ff.scl_s3 & ~st_ff.scl_s2;

   always_comb begin
      nxt_st         = st_ff;
      nxt_st.scl_s1  = serial_clk;
      nxt_st.scl_s2  = st_ff.scl_s1;
      nxt_st.scl_s3  = st_ff.scl_s2;
      nxt_st.sda_s1  = serial_data;
      nxt_st.sda_s2  = st_ff.sda_s1;
      nxt_st.sda_s3  = st_ff.sda_s2;
      nxt_st.done_s1 = lk.frame_done;
      nxt_st.done_s2 = st_ff.done_s1;
      nxt_st.amp_s1  = amp_above_thr;
      nxt_st.amp_s2  = st_ff.amp_s1;
      nxt_st.written = 1'b0;

      // Whole frame: one clock fall after start plus one per bit; else nothing commits
      if (stop_seen && st_ff.falls == 4'(TWCP_FRAME_W + 1)) begin
         if (reg_sel[TWCP_ADDR_BANDWIDTH]) begin
            nxt_st.bandwidth_select = frame_data;
            nxt_st.written          = 1'b1;
         end
         if (reg_sel[TWCP_ADDR_AMP_THR]) begin
            nxt_st.amplitude_and_threshold = frame_data;
            nxt_st.written                 = 1'b1;
         end
         // Other addresses fall through untouched
      end

      // A start opens a frame only while the framer is out of its own reset
      if (start_seen) begin
         nxt_st.falls = ~TWCP_CNT_RST;
         if (st_ff.done_s2) begin
            nxt_st.falls = TWCP_CNT_RST;
         end
      end else if (stop_seen) begin
         nxt_st.falls = ~TWCP_CNT_RST;
      end else if (scl_fall && st_ff.falls != ~TWCP_CNT_RST) begin
         nxt_st.falls = 4'(st_ff.falls + 4'h1);
      end

      band_next  = nxt_st.bandwidth_select[TWCP_BAND_MSB:TWCP_BAND_LSB];
      swing_next = nxt_st.amplitude_and_threshold[TWCP_SWING_MSB:TWCP_SWING_LSB];
      trim_next  = nxt_st.amplitude_and_threshold[TWCP_TRIM_MSB:TWCP_TRIM_LSB];

      nxt_st.band_mhz   = TWCP_BAND_MHZ[band_next];
      nxt_st.swing_mvpp = TWCP_SWING_MVPP[swing_next];
      // Unshunted weights sum to the inverted code times one step
      nxt_st.trim_ohm   = 17'(TWCP_TRIM_FIXED_OHM
                          + 17'(TWCP_TRIM_STEP_OHM * {11'h000, ~trim_next}));
      nxt_st.present    = st_ff.amp_s2;

      if (!rst_n) begin
         nxt_st                         = '0;
         nxt_st.bandwidth_select        = TWCP_BANDWIDTH_RST;
         nxt_st.amplitude_and_threshold = TWCP_AMP_THR_RST;
         nxt_st.band_mhz                = TWCP_BAND_MHZ[TWCP_BANDWIDTH_RST[7:4]];
         nxt_st.swing_mvpp              = TWCP_SWING_MVPP[TWCP_AMP_THR_RST[7:6]];
         nxt_st.trim_ohm                = 17'(TWCP_TRIM_FIXED_OHM
                                          + 17'(TWCP_TRIM_STEP_OHM * 17'h0003F));
         // Pins idle high; a high edge history avoids a false start or stop
         nxt_st.scl_s1                  = 1'b1;
         nxt_st.scl_s2                  = 1'b1;
         nxt_st.scl_s3                  = 1'b1;
         nxt_st.sda_s1                  = 1'b1;
         nxt_st.sda_s2                  = 1'b1;
         nxt_st.sda_s3                  = 1'b1;
         nxt_st.falls                   = ~TWCP_CNT_RST;
      end
   end

   always_ff @(posedge sys_clk) begin
      st_ff <= nxt_st;
   end

   assign band_code     = st_ff.bandwidth_select[TWCP_BAND_MSB:TWCP_BAND_LSB];
   assign swing_code    = st_ff.amplitude_and_threshold[TWCP_SWING_MSB:TWCP_SWING_LSB];
   assign trim_code     = st_ff.amplitude_and_threshold[TWCP_TRIM_MSB:TWCP_TRIM_LSB];
   assign trim_shunt_en = st_ff.amplitude_and_threshold[TWCP_TRIM_MSB:TWCP_TRIM_LSB];
   assign band_mhz      = st_ff.band_mhz;
   assign swing_mvpp    = st_ff.swing_mvpp;
   assign trim_ohm      = st_ff.trim_ohm;
   assign cfg_written   = st_ff.written;

   // Absent flag is open drain: pulled low while signal present, released otherwise
   assign signal_present_flag    = st_ff.present;
   assign input_absent_flag_o    = 1'b0;
   assign input_absent_flag_oe_n = ~st_ff.present;

endmodule : twcp_cfg_port
`default_nettype wire

// ---- hdl/twcp_pkg.sv ----
// Constants and types shared by the two-wire configuration write port
package twcp_pkg;

   localparam int TWCP_ADDR_W  = 3;
   localparam int TWCP_DATA_W  = 8;
   localparam int TWCP_FRAME_W = 11;
   localparam int TWCP_NUM_SEL = 8;

   // Register addresses carried in the frame
   localparam logic [2:0] TWCP_ADDR_BANDWIDTH = 3'h4;
   localparam logic [2:0] TWCP_ADDR_AMP_THR   = 3'h5;

   // Field positions inside the frame and the registers
   localparam int TWCP_FRM_ADDR_LSB  = 8;
   localparam int TWCP_BAND_MSB      = 7;
   localparam int TWCP_BAND_LSB      = 4;
   localparam int TWCP_SWING_MSB     = 7;
   localparam int TWCP_SWING_LSB     = 6;
   localparam int TWCP_TRIM_MSB      = 5;
   localparam int TWCP_TRIM_LSB      = 0;

   // Values after reset: swing code 10 selects 800 mVpp
   localparam logic [7:0] TWCP_BANDWIDTH_RST = 8'h00;
   localparam logic [7:0] TWCP_AMP_THR_RST   = 8'h80;

   // Bit counter: last bit index of a frame
   localparam logic [3:0] TWCP_LAST_BIT = 4'hA;
   localparam logic [3:0] TWCP_CNT_RST  = 4'h0;

   // Bandwidth per code in MHz, falling with the code
   localparam logic [12:0] TWCP_BAND_MHZ [16] = '{
      13'h1126, 13'h0F46, 13'h0D8E, 13'h0BD6, 13'h0AFA, 13'h0906, 13'h071C, 13'h0640,
      13'h060E, 13'h0532, 13'h0456, 13'h0406, 13'h035C, 13'h0334, 13'h02F8, 13'h02DA};

   // Output swing per code in mVpp
   localparam logic [9:0] TWCP_SWING_MVPP [4] = '{10'h190, 10'h258, 10'h320, 10'h3E8};

   // Trim resistor: fixed part plus six binary-weighted parts of 1 to 32 steps
   localparam logic [16:0] TWCP_TRIM_FIXED_OHM = 17'h01F40;
   localparam logic [16:0] TWCP_TRIM_STEP_OHM  = 17'h004E2;

   // Link framing states, Gray coded along idle, shift, done
   typedef enum logic [1:0] {
      TWCP_LS_IDLE  = 2'b00,
      TWCP_LS_SHIFT = 2'b01,
      TWCP_LS_DONE  = 2'b11
   } twcp_link_state_t;

endpackage : twcp_pkg

// ---- hdl/twcp_link_if.sv ----
// Carrier between the serial-clock framer and the system-clock register core
`timescale 1ns/1ps
`default_nettype none
interface twcp_link_if;
   import twcp_pkg::*;
   logic [TWCP_FRAME_W-1:0] frame_word;
   logic                    frame_done;

   modport link (output frame_word, output frame_done);
   modport core (input frame_word, input frame_done);
endinterface : twcp_link_if
`default_nettype wire

// ---- hdl/twcp_framer.sv ----
// Serial-clock domain 11-bit shift register of the two-wire port
`timescale 1ns/1ps
`default_nettype none
module twcp_framer
   import twcp_pkg::*;
(
   input  wire logic   serial_clk,
   input  wire logic   rst_n,
   input  wire logic   serial_data,
   twcp_link_if.link   lk
);

   typedef struct packed {
      logic                    rst_s1;
      logic                    rst_s2;
      logic [TWCP_FRAME_W-1:0] shreg;
   } twcp_framer_st_t;

   twcp_framer_st_t st_ff;
   twcp_framer_st_t nxt_st;
   logic            rise_sda_ff;

   // Data is taken while the clock is high, i.e. at its rising edge
   always_ff @(posedge serial_clk) begin
      rise_sda_ff <= serial_data;
   end

   // Every falling edge out of reset shifts; no clock edge falls between stop and start, so
   // framing is judged on the system side by counting clock falls
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.rst_s1 = rst_n;
      nxt_st.rst_s2 = st_ff.rst_s1;
      if (!st_ff.rst_s2) begin
         nxt_st.shreg = '0;
      end else begin
         nxt_st.shreg = {st_ff.shreg[TWCP_FRAME_W-2:0], rise_sda_ff};
      end
   end

   // Falling edge: the bit sampled at the rise is committed and the reset sync steps
   always_ff @(negedge serial_clk) begin
      st_ff <= nxt_st;
   end

   // Word only changes on falling edges of a later frame, so it is stable at stop
   assign lk.frame_word = st_ff.shreg;
   // Out of reset: a frame that starts now has every bit shifted
   assign lk.frame_done = st_ff.rst_s2;

endmodule : twcp_framer
`default_nettype wire

// ---- testbench/twcp_cfg_port_sva.sv ----
// Concurrent checks on the pins of the configuration port
`timescale 1ns/1ps
`default_nettype none
module twcp_cfg_port_sva (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        serial_clk,
   input wire logic        serial_data,
   input wire logic        amp_above_thr,
   input wire logic [3:0]  band_code,
   input wire logic [1:0]  swing_code,
   input wire logic [5:0]  trim_code,
   input wire logic [5:0]  trim_shunt_en,
   input wire logic [12:0] band_mhz,
   input wire logic [9:0]  swing_mvpp,
   input wire logic [16:0] trim_ohm,
   input wire logic        cfg_written,
   input wire logic        signal_present_flag,
   input wire logic        input_absent_flag_o,
   input wire logic        input_absent_flag_oe_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic       sd_ff;
   logic       stop_hit;
   logic [2:0] up_ff;
   logic [3:0] since_ff;
   // Raw pin sample; the port adds its own sync stages, so the window is wide
   assign stop_hit = serial_clk && serial_data && !sd_ff;
   always_ff @(posedge sys_clk) begin
      sd_ff    <= serial_data;
      up_ff    <= !rst_n ? 3'h0 : up_ff + {2'h0, up_ff != 3'h7};
      since_ff <= !rst_n ? 4'hF : stop_hit ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
   end
   sequence s_stop; serial_clk && $rose(serial_data); endsequence
   property p_follow; up_ff == 3'h7 |-> signal_present_flag == $past(amp_above_thr, 3); endproperty
   a_follow: assert property (p_follow) else $error("present flag lag wrong");
   property p_od; !input_absent_flag_o && input_absent_flag_oe_n == !signal_present_flag; endproperty
   a_od: assert property (p_od) else $error("absent flag pin wrong");
   property p_shunt; trim_ohm == 17'h152DE - 17'h004E2 * {11'h0, trim_shunt_en}; endproperty
   a_shunt: assert property (p_shunt) else $error("shunt enables wrong");
   property p_ohm; trim_ohm == 17'h152DE - 17'h004E2 * {11'h0, trim_code}; endproperty
   a_ohm: assert property (p_ohm) else $error("trim resistance wrong");
   property p_swing; swing_mvpp == 10'h190 + 10'h0C8 * {8'h0, swing_code}; endproperty
   a_swing: assert property (p_swing) else $error("swing amplitude wrong");
   property p_band; band_code == 4'h0 |-> band_mhz == 13'h1126; endproperty
   a_band: assert property (p_band) else $error("top bandwidth wrong");
   property p_quiet; $changed({band_code, swing_code, trim_code}) |-> cfg_written; endproperty
   a_quiet: assert property (p_quiet) else $error("register moved without commit");
   property p_pulse; cfg_written |=> !cfg_written; endproperty
   a_pulse: assert property (p_pulse) else $error("commit pulse too long");
   property p_late; cfg_written |-> since_ff <= 4'h7; endproperty
   a_late: assert property (p_late) else $error("commit without recent stop");
   c_commit: cover property (s_stop ##[2:6] cfg_written);
endmodule : twcp_cfg_port_sva
bind twcp_cfg_port twcp_cfg_port_sva u_sva (.sys_clk, .rst_n, .serial_clk, .serial_data,
   .amp_above_thr, .band_code, .swing_code, .trim_code, .trim_shunt_en, .band_mhz, .swing_mvpp,
   .trim_ohm, .cfg_written, .signal_present_flag, .input_absent_flag_o, .input_absent_flag_oe_n);
`default_nettype wire

// ---- testbench/twcp_host_model.sv ----
// Behavioural controller driving the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module twcp_host_model (
   output logic serial_clk,
   output logic serial_data
);
   // Released lines sit high on the pull-ups
   initial begin
      serial_clk  = 1'b1;
      serial_data = 1'b1;
   end
   // Ticks of 12 ns; ph of 5 or more keeps each phase past what the stop sync needs
   task automatic tick(input int n);
      repeat (n) #12;
   endtask : tick
   task automatic frame(input logic [10:0] w, input int nbits, input bit stop, input int ph);
      serial_data = 1'b1;
      tick(ph);
      serial_clk = 1'b1;
      tick(ph);
      serial_data = 1'b0;
      tick(ph);
      for (int i = 10; i > 10 - nbits; i--) begin
         serial_clk = 1'b0;
         tick(1);
         serial_data = w[i];
         tick(ph);
         serial_clk = 1'b1;
         tick(ph);
      end
      serial_clk = 1'b0;
      tick(1);
      serial_data = 1'b0;
      tick(ph);
      if (stop) begin
         serial_clk = 1'b1;
         tick(ph);
         serial_data = 1'b1;
         tick(2 * ph);
      end
   endtask : frame
endmodule : twcp_host_model
`default_nettype wire

// ---- testbench/two_wire_config_write_port_tb_top.sv ----
// Self-checking bench for the two-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module two_wire_config_write_port_tb_top;
   logic        sys_clk, rst_n, amp_above_thr, serial_clk, serial_data, cfg_written;
   logic        signal_present_flag, input_absent_flag_o, input_absent_flag_oe_n;
   logic [3:0]  band_code;
   logic [1:0]  swing_code;
   logic [5:0]  trim_code, trim_shunt_en;
   logic [12:0] band_mhz;
   logic [9:0]  swing_mvpp;
   logic [16:0] trim_ohm;
   int          mismatches, n_tests, seed, bw, at;
   int          bw_tab [16] = '{32'h1126, 32'hF46, 32'hD8E, 32'hBD6, 32'hAFA, 32'h906, 32'h71C,
      32'h640, 32'h60E, 32'h532, 32'h456, 32'h406, 32'h35C, 32'h334, 32'h2F8, 32'h2DA};
   twcp_cfg_port uut (.sys_clk, .rst_n, .serial_clk, .serial_data, .amp_above_thr, .band_code,
      .swing_code, .trim_code, .trim_shunt_en, .band_mhz, .swing_mvpp, .trim_ohm, .cfg_written,
      .signal_present_flag, .input_absent_flag_o, .input_absent_flag_oe_n);
   twcp_host_model u_host (.serial_clk, .serial_data);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input int exp, input logic [16:0] got);
      n_tests++;
      if (got !== 17'(exp)) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic check_all();
      chk("band_code", bw >> 4, 17'(band_code));
      chk("band_mhz", bw_tab[bw >> 4], 17'(band_mhz));
      chk("swing_code", at >> 6, 17'(swing_code));
      chk("swing_mvpp", 32'h190 + 32'hC8 * (at >> 6), 17'(swing_mvpp));
      chk("trim_code", at & 32'h3F, 17'(trim_code));
      chk("trim_ohm", 32'h152DE - 32'h4E2 * (at & 32'h3F), trim_ohm);
      chk("trim_shunt_en", at & 32'h3F, 17'(trim_shunt_en));
   endtask : check_all
   task automatic wr(input int a, input int d, input int n, input bit stop);
      int pulses;
      pulses = 0;
      fork
         u_host.frame(11'((a << 8) | d), n, stop, 6 + ($unsigned($random(seed)) % 4));
         repeat (250) @(negedge sys_clk) pulses += int'(cfg_written === 1'b1);
      join
      if (stop && n == 11 && a == 4) bw = d;
      if (stop && n == 11 && a == 5) at = d;
      chk("cfg_written", int'(stop && n == 11 && (a == 4 || a == 5)), 17'(pulses));
      check_all();
   endtask : wr
   // The framer resets on serial clock edges, so the host pulses it during reset
   task automatic do_reset();
      rst_n = 1'b0;
      fork
         repeat (8) @(negedge sys_clk);
         repeat (2) u_host.frame(11'h0, 0, 1, 1);
      join
      @(negedge sys_clk);
      rst_n = 1'b1;
      // Two clock falls after release take the framer out of its own reset sync
      repeat (2) u_host.frame(11'h0, 0, 1, 6);
      bw = 32'h0;
      at = 32'h80;
      repeat (4) @(negedge sys_clk);
      check_all();
   endtask : do_reset
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      seed = 32'hF9E9D10F;
      mismatches = 0;
      n_tests = 0;
      amp_above_thr = 1'b0;
      do_reset();
      for (int i = 0; i < 16; i++) wr(4, (i << 4) | ($random(seed) & 15), 11, 1);
      for (int i = 0; i < 6; i++)
         wr(5, i == 4 ? 32'h80 : i == 5 ? 32'hFF : (i << 6) | ($random(seed) & 63), 11, 1);
      for (int i = 0; i < 8; i++) wr(i, $random(seed) & 255, 11, 1);
      wr(5, 32'h3C, 6, 0);
      wr(5, 32'h5A, 11, 1);
      wr(4, 32'hF0, 7, 1);
      wr(0, 32'h00, 11, 1);
      for (int i = 0; i < 8; i++) wr($random(seed) & 7, $random(seed) & 255, 11, 1);
      repeat (60) begin
         @(negedge sys_clk);
         amp_above_thr = 1'($random(seed));
      end
      for (int v = 1; v >= 0; v--) begin
         @(negedge sys_clk);
         amp_above_thr = 1'(v);
         repeat (5) @(negedge sys_clk);
         chk("signal_present_flag", v, 17'(signal_present_flag));
         chk("input_absent_flag_oe_n", 1 - v, 17'(input_absent_flag_oe_n));
      end
      do_reset();
      finish_test();
   end
endmodule : two_wire_config_write_port_tb_top
`default_nettype wire
